/* design/tap_map.svh */
// register codes, lengths and cell layout of the test access port
`ifndef TAP_MAP_SVH
`define TAP_MAP_SVH
`define IR_LEN 10
`define IR_EXTEST 10'h000
`define IR_RECONFIG 10'h001
`define IR_SAMPLE 10'h005
`define IR_IDCODE 10'h006
`define IR_USERCODE 10'h007
`define IR_CLAMP 10'h00A
`define IR_HIGHZ 10'h00B
`define IR_CONFIG_IO 10'h00D
`define IR_BYPASS 10'h3FF
`define IR_CAPTURE 10'h001
`define CODE_LEN 32
`define ID_VER_W 4
`define ID_PART_W 16
`define ID_MFR_W 11
`define ID_LSB 1'b1
`define BSR_LEN_DEF 1317
`define CELLS_PER_PIN 3
`define CELL_IN 0
`define CELL_OUT 1
`define CELL_OE 2
`define IOSTD_W 2
`define PLL_BITS_DEF 8
`define SYNC_W 3
`endif

/* design/tap_pkg.sv */
// types shared by the test access port modules
package tap_pkg;
  typedef enum logic [15:0] {
    st_tlr = 16'h0001,
    st_idle = 16'h0002,
    st_sel_dr = 16'h0004,
    st_cap_dr = 16'h0008,
    st_sh_dr = 16'h0010,
    st_ex1_dr = 16'h0020,
    st_pau_dr = 16'h0040,
    st_ex2_dr = 16'h0080,
    st_upd_dr = 16'h0100,
    st_sel_ir = 16'h0200,
    st_cap_ir = 16'h0400,
    st_sh_ir = 16'h0800,
    st_ex1_ir = 16'h1000,
    st_pau_ir = 16'h2000,
    st_ex2_ir = 16'h4000,
    st_upd_ir = 16'h8000
  } tap_state_t;

  typedef enum logic [2:0] {
    sel_bypass = 3'h0,
    sel_bsr = 3'h1,
    sel_code = 3'h2,
    sel_iostd = 3'h3
  } chain_sel_t;
endpackage : tap_pkg

/* design/tap_sync.sv */
// two-stage synchroniser for levels from outside the clock domain
`timescale 1ns/1ps
module tap_sync #(
  parameter int W = 1
) (
  input wire logic clk, // system clock
  input wire logic srst, // synchronous reset
  input wire logic [W-1:0] d, // asynchronous level
  output logic [W-1:0] q // synchronised level
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_t;

  sync_t r;
  sync_t next_r;

  always_comb begin
    next_r.s1 = d;
    next_r.s2 = r.s1;
    if (srst) begin
      next_r = '0;
    end
  end

  always_ff @(posedge clk) begin
    r <= next_r;
  end

  assign q = r.s2;
endmodule : tap_sync

/* design/tap_port.sv */
// boundary-scan test access port with instruction decode and pin control
// Notes on behaviour
// R1: instruction register is 10 bits, shifted tdi to tdo in instruction scan
// R2: sample/preload captures pins and preloads pattern, pins stay normal
// R3: extest drives pins from scan cells and captures pin inputs
// R4: bypass puts one-bit register between tdi and tdo
// R5: usercode shifts out a 32-bit user code
// R6: idcode shifts out the identification register
// R7: highz selects bypass and floats every user pin
// R8: clamp selects bypass and holds pins at scan cell values
// R9: reconfig instruction emits a reconfiguration trigger, request pin untouched
// R10: io-standard instruction accepted anytime; stops configuration in progress
// R11: io-standard instruction drives status pin low until reconfigured
// R12: io standard of every pin rewritable through the scan chain
// R13: scan testing only outside configuration; controller avoids it then
// R14: pll bits in chain before configuration, removed once configured
// R15: bus-hold or pull-up overrides forced high impedance
// R16: boundary register length is a per-variant constant, 1317 to 3777
// R17: outputs undriven at power-up until configuration completes
// R18: id code is version, part number, maker, then one bit
// R19: id code least significant bit is always one
// R20: standard sixteen-state controller; update states apply new contents
// R21: undefined instruction codes act as bypass
`timescale 1ns/1ps
`include "tap_map.svh"
module tap_port
  import tap_pkg::*;
#(
  parameter int BSR_LEN = `BSR_LEN_DEF, // R16
  parameter int PLL_BITS = `PLL_BITS_DEF,
  // identification fields: values arbitrary
  parameter logic [`ID_VER_W-1:0] ID_VERSION = 4'h1,
  parameter logic [`ID_PART_W-1:0] ID_PART = 16'h5A3C,
  parameter logic [`ID_MFR_W-1:0] ID_MFR = 11'h2B5
) (
  input wire logic clk, // system clock
  input wire logic srst, // synchronous reset
  input wire logic tck, // test clock pin
  input wire logic tms, // test mode pin
  input wire logic tdi, // test data in pin
  output logic tdo, // test data out level
  output logic tdo_oe, // test data out enable
  input wire logic [BSR_LEN/`CELLS_PER_PIN-1:0] pin_in, // pin levels
  input wire logic [BSR_LEN/`CELLS_PER_PIN-1:0] core_out, // core data
  input wire logic [BSR_LEN/`CELLS_PER_PIN-1:0] core_oe, // core enables
  input wire logic [BSR_LEN/`CELLS_PER_PIN-1:0] keep_en, // hold or pull-up
  input wire logic config_done, // configuration complete
  input wire logic config_busy, // configuration in progress
  input wire logic [`CODE_LEN-1:0] user_code, // user code value
  output logic [BSR_LEN/`CELLS_PER_PIN-1:0] pin_out, // pin data
  output logic [BSR_LEN/`CELLS_PER_PIN-1:0] pin_oe, // pin enables
  output logic [BSR_LEN/`CELLS_PER_PIN-1:0] pin_weak, // keeper active
  output logic [PLL_BITS-1:0] pll_cfg, // pll reconfiguration bits
  output logic [BSR_LEN/`CELLS_PER_PIN*`IOSTD_W-1:0] io_std, // io standard
  output logic reconfig_trigger, // emulated reconfig request pulse
  output logic config_stop, // stop configuration pulse
  output logic config_state_out, // status pin level
  output logic config_state_oe // status pin pulled low
);
  localparam int NPINS = BSR_LEN / `CELLS_PER_PIN;
  localparam int IOW = NPINS * `IOSTD_W;
  localparam int NS = NPINS + `SYNC_W;

  typedef struct packed {
    tap_state_t st;
    logic tck_q;
    logic [`IR_LEN-1:0] ir_sh;
    logic [`IR_LEN-1:0] ir;
    logic byp;
    logic [`CODE_LEN-1:0] code_sh;
    logic [BSR_LEN-1:0] bsr_sh;
    logic [BSR_LEN-1:0] bsr_up;
    logic [PLL_BITS-1:0] pll_sh;
    logic [PLL_BITS-1:0] pll;
    logic [IOW-1:0] io_sh;
    logic [IOW-1:0] io;
    logic tdo;
    logic tdo_oe;
    logic [NPINS-1:0] pin_out;
    logic [NPINS-1:0] pin_oe;
    logic [NPINS-1:0] pin_weak;
    logic reconfig;
    logic stop;
    logic hold;
    logic status_out;
    logic done_q;
  } regs_t;

  regs_t r;
  regs_t next_r;
  logic [NS-1:0] s;
  logic s_tck;
  logic s_tms;
  logic s_tdi;
  logic [NPINS-1:0] s_pin;

  tap_sync #(.W(NS)) u_sync (
    .clk(clk),
    .srst(srst),
    .d({tck, tms, tdi, pin_in}),
    .q(s)
  );

  assign s_tck = s[NS-1];
  assign s_tms = s[NS-2];
  assign s_tdi = s[NS-3];
  assign s_pin = s[NPINS-1:0];

  // controller state walk
  function automatic tap_state_t step(tap_state_t st, logic m);
    case (st)
      st_tlr: step = m ? st_tlr : st_idle;
      st_idle: step = m ? st_sel_dr : st_idle;
      st_sel_dr: step = m ? st_sel_ir : st_cap_dr;
      st_cap_dr: step = m ? st_ex1_dr : st_sh_dr;
      st_sh_dr: step = m ? st_ex1_dr : st_sh_dr;
      st_ex1_dr: step = m ? st_upd_dr : st_pau_dr;
      st_pau_dr: step = m ? st_ex2_dr : st_pau_dr;
      st_ex2_dr: step = m ? st_upd_dr : st_sh_dr;
      st_upd_dr: step = m ? st_sel_dr : st_idle;
      st_sel_ir: step = m ? st_tlr : st_cap_ir;
      st_cap_ir: step = m ? st_ex1_ir : st_sh_ir;
      st_sh_ir: step = m ? st_ex1_ir : st_sh_ir;
      st_ex1_ir: step = m ? st_upd_ir : st_pau_ir;
      st_pau_ir: step = m ? st_ex2_ir : st_pau_ir;
      st_ex2_ir: step = m ? st_upd_ir : st_sh_ir;
      st_upd_ir: step = m ? st_sel_dr : st_idle;
      default: step = st_tlr;
    endcase
  endfunction : step

  // data register chosen by an instruction
  function automatic chain_sel_t sel_of(logic [`IR_LEN-1:0] ir);
    case (ir)
      `IR_SAMPLE, `IR_EXTEST: sel_of = sel_bsr; // R2 R3
      `IR_IDCODE, `IR_USERCODE: sel_of = sel_code; // R5 R6
      `IR_CONFIG_IO: sel_of = sel_iostd; // R12
      default: sel_of = sel_bypass; // R4 R7 R8 R21
    endcase
  endfunction : sel_of

  logic rise;
  logic fall;
  logic scan_ok;
  logic pll_in_chain;
  chain_sel_t sel;

  always_comb begin
    rise = s_tck & ~r.tck_q;
    fall = ~s_tck & r.tck_q;
    scan_ok = ~config_busy; // R13
    pll_in_chain = ~config_done; // R14
    sel = sel_of(r.ir);
  end

  always_comb begin
    next_r = r;
    next_r.tck_q = s_tck;
    next_r.done_q = config_done;
    next_r.reconfig = 1'b0;
    next_r.stop = 1'b0;
    if (rise) begin
      next_r.st = step(r.st, s_tms); // R20
      case (r.st)
        st_tlr: begin
          next_r.ir = `IR_IDCODE;
        end
        st_cap_ir: begin
          next_r.ir_sh = `IR_CAPTURE;
        end
        st_sh_ir: begin
          next_r.ir_sh = {s_tdi, r.ir_sh[`IR_LEN-1:1]}; // R1
        end
        st_cap_dr: begin
          next_r.byp = 1'b0; // R4
          next_r.pll_sh = r.pll;
          next_r.io_sh = r.io;
          if (r.ir == `IR_USERCODE) begin
            next_r.code_sh = user_code; // R5
          end else begin
            next_r.code_sh = {ID_VERSION, ID_PART, ID_MFR, `ID_LSB}; // R18 R19
          end
          for (int i = 0; i < NPINS; i++) begin
            next_r.bsr_sh[`CELLS_PER_PIN*i+`CELL_IN] = s_pin[i]; // R2 R3
            next_r.bsr_sh[`CELLS_PER_PIN*i+`CELL_OUT] = r.pin_out[i];
            next_r.bsr_sh[`CELLS_PER_PIN*i+`CELL_OE] = r.pin_oe[i];
          end
        end
        st_sh_dr: begin
          case (sel)
            sel_bsr: begin
              if (pll_in_chain) begin
                next_r.pll_sh = {s_tdi, r.pll_sh[PLL_BITS-1:1]}; // R14
                next_r.bsr_sh = {r.pll_sh[0], r.bsr_sh[BSR_LEN-1:1]};
              end else begin
                next_r.bsr_sh = {s_tdi, r.bsr_sh[BSR_LEN-1:1]};
              end
            end
            sel_code: begin
              next_r.code_sh = {s_tdi, r.code_sh[`CODE_LEN-1:1]}; // R5 R6
            end
            sel_iostd: begin
              next_r.io_sh = {s_tdi, r.io_sh[IOW-1:1]}; // R12
            end
            default: begin
              next_r.byp = s_tdi; // R4
            end
          endcase
        end
        default: begin
        end
      endcase
    end
    if (fall) begin
      next_r.tdo_oe = (r.st == st_sh_dr) || (r.st == st_sh_ir);
      if (r.st == st_sh_ir) begin
        next_r.tdo = r.ir_sh[0]; // R1
      end else begin
        case (sel)
          sel_bsr: next_r.tdo = r.bsr_sh[0];
          sel_code: next_r.tdo = r.code_sh[0];
          sel_iostd: next_r.tdo = r.io_sh[0];
          default: next_r.tdo = r.byp;
        endcase
      end
      if (r.st == st_upd_ir) begin
        next_r.ir = r.ir_sh; // R20
        next_r.reconfig = (r.ir_sh == `IR_RECONFIG); // R9
        next_r.stop = (r.ir_sh == `IR_CONFIG_IO) && config_busy; // R10
      end
      if (r.st == st_upd_dr) begin
        if (sel == sel_bsr) begin
          next_r.bsr_up = r.bsr_sh; // R2 R3
          if (pll_in_chain) begin
            next_r.pll = r.pll_sh; // R14
          end
        end
        if (sel == sel_iostd) begin
          next_r.io = r.io_sh; // R12
        end
      end
    end
    // status pin stays low until a new configuration completes
    next_r.hold = (fall && r.st == st_upd_ir && r.ir_sh == `IR_CONFIG_IO)
      || (r.hold && !(config_done && !r.done_q)); // R11
    next_r.status_out = ~next_r.hold;
    for (int i = 0; i < NPINS; i++) begin
      next_r.pin_weak[i] = 1'b0;
      if (scan_ok && r.ir == `IR_HIGHZ) begin
        next_r.pin_out[i] = 1'b0; // R7
        next_r.pin_oe[i] = 1'b0;
        next_r.pin_weak[i] = keep_en[i]; // R15
      end else if (scan_ok && (r.ir == `IR_EXTEST || r.ir == `IR_CLAMP)) begin
        next_r.pin_out[i] = r.bsr_up[`CELLS_PER_PIN*i+`CELL_OUT]; // R3 R8
        next_r.pin_oe[i] = r.bsr_up[`CELLS_PER_PIN*i+`CELL_OE];
        next_r.pin_weak[i] = keep_en[i] & ~next_r.pin_oe[i]; // R15
      end else if (config_done) begin
        next_r.pin_out[i] = core_out[i]; // R2
        next_r.pin_oe[i] = core_oe[i];
      end else begin
        next_r.pin_out[i] = 1'b0; // R17
        next_r.pin_oe[i] = 1'b0;
      end
    end
    if (srst) begin
      next_r = '0;
      next_r.st = st_tlr;
      next_r.ir = `IR_IDCODE;
      next_r.status_out = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    r <= next_r;
  end

  assign tdo = r.tdo;
  assign tdo_oe = r.tdo_oe;
  assign pin_out = r.pin_out;
  assign pin_oe = r.pin_oe;
  assign pin_weak = r.pin_weak;
  assign pll_cfg = r.pll;
  assign io_std = r.io;
  assign reconfig_trigger = r.reconfig;
  assign config_stop = r.stop;
  assign config_state_out = r.status_out;
  assign config_state_oe = r.hold;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  ir_update_a: assert property ( // R20
    (fall && r.st == st_upd_ir) |=> (r.ir == $past(r.ir_sh))
  ) else $error("instruction not updated from shift stage");

  bypass_cap_a: assert property ( // R4
    (rise && r.st == st_cap_dr && sel == sel_bypass && r.ir != `IR_SAMPLE)
      |=> (r.byp == 1'b0)
  ) else $error("bypass bit not cleared at capture");

  idcode_cap_a: assert property ( // R19
    (rise && r.st == st_cap_dr && r.ir == `IR_IDCODE)
      |=> (r.code_sh[0] == `ID_LSB
        && r.code_sh[`CODE_LEN-1 -: `ID_VER_W] == ID_VERSION)
  ) else $error("identification code captured wrongly");

  usercode_cap_a: assert property ( // R5
    (rise && r.st == st_cap_dr && r.ir == `IR_USERCODE)
      |=> (r.code_sh == $past(user_code))
  ) else $error("user code not captured");

  highz_pins_a: assert property ( // R7
    (r.ir == `IR_HIGHZ && !config_busy) |=> (pin_oe == '0)
  ) else $error("pin driven under highz");

  clamp_pins_a: assert property ( // R8
    (r.ir == `IR_CLAMP && !config_busy)
      |=> (pin_out[0] == $past(r.bsr_up[`CELL_OUT])
        && pin_oe[0] == $past(r.bsr_up[`CELL_OE]))
  ) else $error("clamped pin differs from scan cell");

  reconfig_pulse_a: assert property ( // R9
    (fall && r.st == st_upd_ir && r.ir_sh == `IR_RECONFIG)
      |=> reconfig_trigger ##1 !reconfig_trigger
  ) else $error("reconfiguration trigger not one pulse");

  stop_pulse_a: assert property ( // R10
    (fall && r.st == st_upd_ir && r.ir_sh == `IR_CONFIG_IO && config_busy)
      |=> config_stop
  ) else $error("configuration not stopped");

  status_hold_a: assert property ( // R11
    (config_state_oe && !(config_done && !r.done_q))
      |=> (config_state_oe && !config_state_out)
  ) else $error("status pin released early");

  powerup_z_a: assert property ( // R17
    (!config_done && r.ir == `IR_SAMPLE) |=> (pin_oe == '0)
  ) else $error("pin driven before configuration");

  pll_frozen_a: assert property ( // R14
    (config_done && r.done_q) |=> $stable(pll_cfg)
  ) else $error("pll bits changed after configuration");

  idcode_cov: cover property (
    fall && r.st == st_sh_dr && r.ir == `IR_IDCODE
  );
  extest_cov: cover property (
    r.ir == `IR_EXTEST && !config_busy && pin_oe != '0
  );
  cfgio_cov: cover property (
    config_state_oe ##1 !config_state_oe
  );
endmodule : tap_port

/* verification/tap_host.sv */
// test controller model that drives the serial test port
`timescale 1ns/1ps
module tap_host (
  output logic tck, // test clock
  output logic tms, // test mode
  output logic tdi, // test data in
  input wire logic tdo, // test data out
  input wire logic tdo_oe // test data out enable
);
  // test clock idles low between frames
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  // one test clock; tdo read late in the high phase
  task automatic step(input logic m, input logic b, output logic q);
    tms = m;
    tdi = b;
    #160;
    tck = 1'b1;
    #150;
    q = tdo_oe ? tdo : 1'bx;
    #10;
    tck = 1'b0;
  endtask : step

  task automatic reset_tap();
    logic q;
    #7;
    repeat (5) step(1'b1, ~tdi, q);
    step(1'b0, ~tdi, q);
  endtask : reset_tap

  // one scan from idle back to idle, lsb first
  task automatic scan(input logic ir, input int n, input logic [63:0] din,
      output logic [63:0] dout);
    logic q;
    dout = '0;
    #7;
    step(1'b1, ~tdi, q);
    if (ir) step(1'b1, ~tdi, q);
    step(1'b0, ~tdi, q);
    step(1'b0, ~tdi, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, ~tdi, q);
    step(1'b0, ~tdi, q);
    tdi = ~tdi;
  endtask : scan
endmodule : tap_host

/* verification/boundary_scan_tap_instructions_tb.sv */
// self-checking bench for the boundary-scan test access port
`timescale 1ns/1ps
module boundary_scan_tap_instructions_tb;
  localparam logic [3:0] VER = 4'h9; // value arbitrary
  localparam logic [15:0] PART = 16'h1E47; // value arbitrary
  localparam logic [10:0] MFR = 11'h35A; // value arbitrary
  logic clk, srst, tck, tms, tdi, tdo, tdo_oe;
  logic [2:0] pin_in, core_out, core_oe, keep_en;
  logic [2:0] pin_out, pin_oe, pin_weak;
  logic config_done, config_busy, reconfig_trigger, config_stop;
  logic config_state_out, config_state_oe;
  logic [31:0] user_code;
  logic [7:0] pll_cfg;
  logic [5:0] io_std;
  logic [63:0] d;
  int error_cnt = 0;
  int n_compared = 0;
  int cycles = 0;
  int n_trig = 0;
  int n_stop = 0;

  tap_port #(.BSR_LEN(9), .PLL_BITS(8), .ID_VERSION(VER), .ID_PART(PART),
    .ID_MFR(MFR)) i_dut (
    .clk(clk), .srst(srst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdo_oe(tdo_oe), .pin_in(pin_in), .core_out(core_out),
    .core_oe(core_oe), .keep_en(keep_en), .config_done(config_done),
    .config_busy(config_busy), .user_code(user_code), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_weak(pin_weak), .pll_cfg(pll_cfg),
    .io_std(io_std), .reconfig_trigger(reconfig_trigger),
    .config_stop(config_stop), .config_state_out(config_state_out),
    .config_state_oe(config_state_oe));

  tap_host i_host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdo_oe(tdo_oe));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (reconfig_trigger === 1'b1) n_trig <= n_trig + 1;
    if (config_stop === 1'b1) n_stop <= n_stop + 1;
    if (cycles == 30000) begin
      error_cnt = error_cnt + 1;
      $display("ERROR timeout expected 0 seen %0d", cycles);
      end_of_test();
    end
  end

  task automatic check(input string what, input logic [63:0] seen,
      input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test

  task automatic waitc(input int n);
    repeat (n) @(posedge clk);
  endtask : waitc

  task automatic load(input logic [9:0] code);
    i_host.scan(1'b1, 10, {54'h0, code}, d);
    check("ir capture", d[9:0], 10'h001);
    waitc(4);
  endtask : load

  task automatic t_idcode();
    i_host.scan(1'b0, 32, 64'h0, d);
    check("idcode", d[31:0], {VER, PART, MFR, 1'b1});
    $display("test idcode done");
  endtask : t_idcode

  task automatic t_sample_pll();
    load(10'h005);
    i_host.scan(1'b0, 17, {47'h0, 8'hA6, 9'h136}, d);
    waitc(4);
    check("captured pins", {d[6], d[3], d[0]}, 3'h5);
    check("pll bits", pll_cfg, 8'hA6);
    check("pin_oe", pin_oe, 3'h0);
    @(posedge clk);
    config_done <= 1'b1;
    waitc(6);
    check("pin_out", pin_out, 3'h6);
    check("pin_oe", pin_oe, 3'h3);
    i_host.scan(1'b0, 17, {47'h0, 9'h136, 8'h5C}, d);
    waitc(4);
    check("chain length", d[16:9], 8'h5C);
    check("pll bits", pll_cfg, 8'hA6);
    check("pin_oe", pin_oe, 3'h3);
    $display("test sample and pll done");
  endtask : t_sample_pll

  task automatic t_extest();
    @(posedge clk);
    pin_in <= 3'h2;
    load(10'h000);
    check("pin_out", pin_out, 3'h3);
    check("pin_oe", pin_oe, 3'h7);
    i_host.scan(1'b0, 9, {55'h0, 9'h136}, d);
    check("captured pins", {d[6], d[3], d[0]}, 3'h2);
    @(posedge clk);
    config_busy <= 1'b1;
    waitc(6);
    check("pin_oe", pin_oe, 3'h3);
    @(posedge clk);
    config_busy <= 1'b0;
    waitc(6);
    check("pin_oe", pin_oe, 3'h7);
    load(10'h00A);
    check("pin_out", pin_out, 3'h3);
    check("pin_oe", pin_oe, 3'h7);
    load(10'h00B);
    check("pin_oe", pin_oe, 3'h0);
    check("pin_weak", pin_weak, 3'h2);
    $display("test extest clamp highz done");
  endtask : t_extest

  task automatic t_bypass();
    logic [9:0] codes [5] = '{10'h3FF, 10'h00B, 10'h00A, 10'h155, 10'h3F0};
    foreach (codes[k]) begin
      load(codes[k]);
      i_host.scan(1'b0, 8, 64'hB4, d);
      check("bypass path", d[7:0], 8'h68);
    end
    $display("test bypass done");
  endtask : t_bypass

  task automatic t_reconfig();
    int n0;
    n0 = n_trig;
    load(10'h001);
    check("trigger pulses", n_trig - n0, 1);
    $display("test reconfig done");
  endtask : t_reconfig

  task automatic t_config_io();
    int s0;
    @(posedge clk);
    config_done <= 1'b0;
    config_busy <= 1'b1;
    s0 = n_stop;
    load(10'h00D);
    check("stop pulses", n_stop - s0, 1);
    check("status drive", config_state_oe, 1'b1);
    check("status level", config_state_out, 1'b0);
    i_host.scan(1'b0, 6, 64'h27, d);
    waitc(4);
    check("io standard", io_std, 6'h27);
    @(posedge clk);
    config_busy <= 1'b0;
    config_done <= 1'b1;
    waitc(4);
    check("status drive", config_state_oe, 1'b0);
    load(10'h00D);
    check("stop pulses", n_stop - s0, 1);
    check("status drive", config_state_oe, 1'b1);
    $display("test config io done");
  endtask : t_config_io

  task automatic t_user_tlr();
    load(10'h007);
    i_host.scan(1'b0, 32, 64'h0, d);
    check("usercode", d[31:0], 32'hC3A50F96);
    i_host.reset_tap();
    t_idcode();
    $display("test usercode and reset done");
  endtask : t_user_tlr

  initial begin
    srst = 1'b1;
    pin_in = 3'h5;
    core_out = 3'h6;
    core_oe = 3'h3;
    keep_en = 3'h2;
    config_done = 1'b0;
    config_busy = 1'b0;
    user_code = 32'hC3A50F96;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    waitc(4);
    check("pin_oe", pin_oe, 3'h0);
    i_host.reset_tap();
    t_idcode();
    t_sample_pll();
    t_extest();
    t_bypass();
    t_reconfig();
    t_config_io();
    t_user_tlr();
    end_of_test();
  end
endmodule : boundary_scan_tap_instructions_tb
